// file: core/dscif_pkg.sv
/*
 Constants, command codes and types of the serial command front end
 of an eight-channel voltage-output converter.
 Assumes a single 40 MHz system clock; the serial pins are asynchronous to it.
*/
package dscif_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CODE_W = 12;
   localparam int NUM_CH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int DATA_MSB = 11;
   localparam int CH_A = 0;
   localparam logic [CNT_W-1:0] EDGES_KEEP = 5'h0f;
   localparam logic [CNT_W-1:0] EDGES_FULL = 5'h10;
   localparam logic [CNT_W-1:0] EDGES_SAT = 5'h1f;
   localparam logic [CODE_W-1:0] MASK_12BIT = 12'hfff;
   localparam logic [CODE_W-1:0] MASK_10BIT = 12'hffc;
   localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
   localparam logic [FRAME_BITS-1:0] FRAME_CLEAR = 16'h0000;
   localparam logic [3:0] CMD_SLEEP_2K5 = 4'hf;
   localparam logic [3:0] CMD_SLEEP_100K = 4'he;
   localparam logic [3:0] CMD_SLEEP_HIZ = 4'hd;
   localparam logic [3:0] CMD_BROADCAST = 4'hc;
   localparam logic [3:0] CMD_UPDATE_A = 4'hb;
   localparam logic [3:0] CMD_UPDATE_SEL = 4'ha;
   localparam logic [3:0] CMD_WRITE_THROUGH_MODE = 4'h9;
   localparam logic [3:0] CMD_BUFFERED_WRITE_MODE = 4'h8;

   typedef enum logic [1:0]
   {
      SLEEP_AWAKE = 2'h0,
      SLEEP_2K5 = 2'h1,
      SLEEP_100K = 2'h2,
      SLEEP_HIZ = 2'h3
   } dscif_sleep_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } dscif_state_t;
endpackage

// file: core/dscif_stream_if.sv
/*
 Valid/ready frame stream between the serial front end and its frame FIFO.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface dscif_stream_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] wdata;
   logic wvalid;
   logic wready;
   logic [WIDTH-1:0] rdata;
   logic rvalid;
   logic rready;

   modport prod (output wdata, output wvalid, input wready,
                 input rdata, input rvalid, output rready);
   modport store (input wdata, input wvalid, output wready,
                  output rdata, output rvalid, input rready);
endinterface

// file: core/dscif_fifo.sv
/*
 Synchronous frame FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two; reset is asynchronous, active high.
*/
`timescale 1ns/1ps
module dscif_fifo
   import dscif_pkg::*;
#(
   parameter int WIDTH = FRAME_BITS,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   dscif_stream_if.store s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign push = s.wvalid && s.wready;
   assign pop = s.rvalid && s.rready;
   assign s.wready = count_ff != (AW+1)'(DEPTH);
   assign s.rvalid = count_ff != '0;
   assign s.rdata = mem_ff[rd_ptr_ff];

   // Storage has no reset so it can map onto plain memory
   always_ff @(posedge i_clk)
   begin
      if (push)
         mem_ff[wr_ptr_ff] <= s.wdata;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
         if (pop)
            rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
         if (push && !pop)
            count_ff <= (AW+1)'(count_ff + 1'b1);
         else if (pop && !push)
            count_ff <= (AW+1)'(count_ff - 1'b1);
      end
   end

   no_overflow_a: assert property (@(posedge i_clk) disable iff (i_rst)
      count_ff <= (AW+1)'(DEPTH)) else $error("fifo holds more words than its depth");
endmodule

// file: core/dscif_core.sv
/*
 Serial command front end: samples frame select, serial clock and data,
 shifts 16-bit frames, replays them on the chain output and executes them
 on eight channels of holding and output registers.
 Assumes the serial pins are asynchronous and the serial clock is slow enough
 for the system clock to see each level at least twice.
*/
`timescale 1ns/1ps
module dscif_core
   import dscif_pkg::*;
#(
   parameter int DAC_BITS = 12,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_frame_sel_n,
   input wire logic i_sclk,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic [NUM_CH*CODE_W-1:0] o_dac_code,
   output logic [NUM_CH*2-1:0] o_sleep_state,
   output logic o_write_through
);
   localparam logic [CODE_W-1:0] DATA_MASK = (DAC_BITS == 10) ? MASK_10BIT : MASK_12BIT;

   // Pin synchronisers and edge history
   logic fs_meta_ff;
   logic fs_sync_ff;
   logic fs_prev_ff;
   logic sclk_meta_ff;
   logic sclk_sync_ff;
   logic sclk_prev_ff;
   logic sdi_meta_ff;
   logic sdi_sync_ff;

   // Frame shifter
   logic [FRAME_BITS-1:0] sr_ff;
   logic [FRAME_BITS-1:0] sr_base;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] cnt_base;
   logic sdo_ff;
   logic fs_fall;
   logic fs_rise;
   logic sclk_fall;
   logic shift_en;

   // Captured frame waiting for FIFO room
   logic pend_ff;
   logic [FRAME_BITS-1:0] pend_frame_ff;

   // Command execution
   dscif_state_t state_ff;
   logic [FRAME_BITS-1:0] cmd_ff;
   logic write_through_mode_ff;
   logic exec;
   logic [3:0] cmd_code;
   logic [CODE_W-1:0] cmd_data;

   // Channel registers
   logic [CODE_W-1:0] hold_ff [NUM_CH];
   logic [CODE_W-1:0] out_ff [NUM_CH];
   dscif_sleep_t sleep_ff [NUM_CH];

   dscif_stream_if #(.WIDTH(FRAME_BITS)) frames ();

   dscif_fifo #(.WIDTH(FRAME_BITS), .DEPTH(DEPTH)) u_fifo
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .s(frames.store)
   );

   // Two flip-flops per pin before any logic looks at it
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         fs_meta_ff <= 1'b1;
         fs_sync_ff <= 1'b1;
         fs_prev_ff <= 1'b1;
      end
      else
      begin
         fs_meta_ff <= i_frame_sel_n;
         fs_sync_ff <= fs_meta_ff;
         fs_prev_ff <= fs_sync_ff;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sclk_meta_ff <= 1'b0;
         sclk_sync_ff <= 1'b0;
         sclk_prev_ff <= 1'b0;
      end
      else
      begin
         sclk_meta_ff <= i_sclk;
         sclk_sync_ff <= sclk_meta_ff;
         sclk_prev_ff <= sclk_sync_ff;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sdi_meta_ff <= 1'b0;
         sdi_sync_ff <= 1'b0;
      end
      else
      begin
         sdi_meta_ff <= i_sdi;
         sdi_sync_ff <= sdi_meta_ff;
      end
   end

   assign fs_fall = fs_prev_ff && !fs_sync_ff;
   assign fs_rise = !fs_prev_ff && fs_sync_ff;
   assign sclk_fall = sclk_prev_ff && !sclk_sync_ff;
   // Shifting only while frame select is low
   assign shift_en = sclk_fall && !fs_sync_ff;

   // A new frame starts from a clean shifter, so the chain output is low
   // for the first sixteen edges instead of replaying stale bits
   always_comb
   begin
      sr_base = sr_ff;
      cnt_base = cnt_ff;
      if (fs_fall)
      begin
         sr_base = FRAME_CLEAR;
         cnt_base = '0;
      end
   end

   // MSB first: the first bit ends up in bit 15 after sixteen edges
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         sr_ff <= FRAME_CLEAR;
      else if (shift_en)
         sr_ff <= {sr_base[FRAME_BITS-2:0], sdi_sync_ff};
      else
         sr_ff <= sr_base;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         cnt_ff <= '0;
      else if (shift_en && cnt_base != EDGES_SAT)
         cnt_ff <= CNT_W'(cnt_base + 1'b1);
      else
         cnt_ff <= cnt_base;
   end

   // The bit leaving the top of the shifter goes out on the same falling edge
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         sdo_ff <= 1'b0;
      else if (shift_en)
         sdo_ff <= sr_base[FRAME_BITS-1];
   end

   // Frames shorter than sixteen edges are dropped. A frame arriving while
   // the previous one still waits for FIFO room is lost; at legal link
   // rates the FIFO never holds more than one frame.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pend_ff <= 1'b0;
         pend_frame_ff <= FRAME_CLEAR;
      end
      else if (fs_rise && cnt_ff >= EDGES_FULL && !pend_ff)
      begin
         pend_ff <= 1'b1;
         pend_frame_ff <= sr_ff;
      end
      else if (pend_ff && frames.wready)
         pend_ff <= 1'b0;
   end

   assign frames.wvalid = pend_ff;
   assign frames.wdata = pend_frame_ff;
   assign frames.rready = state_ff == ST_IDLE;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_ff <= ST_IDLE;
         cmd_ff <= FRAME_CLEAR;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               if (frames.rvalid)
               begin
                  cmd_ff <= frames.rdata;
                  state_ff <= ST_EXEC;
               end
            end
            ST_EXEC:
               state_ff <= ST_IDLE;
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   assign exec = state_ff == ST_EXEC;
   assign cmd_code = cmd_ff[CMD_MSB:CMD_LSB];
   assign cmd_data = cmd_ff[DATA_MSB:0] & DATA_MASK;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         write_through_mode_ff <= 1'b0;
      else if (exec && cmd_code == CMD_WRITE_THROUGH_MODE)
         write_through_mode_ff <= 1'b1;
      else if (exec && cmd_code == CMD_BUFFERED_WRITE_MODE)
         write_through_mode_ff <= 1'b0;
   end

   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++)
      begin : g_ch
         logic own_write;
         logic load_hold;
         logic load_out;
         logic copy_out;
         logic sleep_sel;

         // Codes with bit 15 clear address channel A..H directly
         assign own_write = exec && !cmd_code[3] && cmd_code == 4'(i);
         assign load_hold = own_write || (exec && cmd_code == CMD_BROADCAST)
                            || (exec && cmd_code == CMD_UPDATE_A && i == CH_A);
         assign load_out = (own_write && write_through_mode_ff) || (exec && cmd_code == CMD_BROADCAST)
                           || (exec && cmd_code == CMD_UPDATE_A && i == CH_A);
         assign copy_out = (exec && cmd_code == CMD_UPDATE_A && i != CH_A)
                           || (exec && cmd_code == CMD_UPDATE_SEL && cmd_ff[i]);
         assign sleep_sel = exec && cmd_ff[i];

         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
               hold_ff[i] <= CODE_RESET;
            else if (load_hold)
               hold_ff[i] <= cmd_data;
         end

         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
               out_ff[i] <= CODE_RESET;
            else if (load_out)
               out_ff[i] <= cmd_data;
            else if (copy_out)
               out_ff[i] <= hold_ff[i];
         end

         // Any output register update brings the channel back out of sleep
         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
               sleep_ff[i] <= SLEEP_AWAKE;
            else if (sleep_sel && cmd_code == CMD_SLEEP_2K5)
               sleep_ff[i] <= SLEEP_2K5;
            else if (sleep_sel && cmd_code == CMD_SLEEP_100K)
               sleep_ff[i] <= SLEEP_100K;
            else if (sleep_sel && cmd_code == CMD_SLEEP_HIZ)
               sleep_ff[i] <= SLEEP_HIZ;
            else if (load_out || copy_out)
               sleep_ff[i] <= SLEEP_AWAKE;
         end

         assign o_dac_code[i*CODE_W +: CODE_W] = out_ff[i];
         assign o_sleep_state[i*2 +: 2] = sleep_ff[i];
      end
   endgenerate

   assign o_sdo = sdo_ff;
   assign o_write_through = write_through_mode_ff;

   shift_in_a: assert property (@(posedge i_clk) disable iff (i_rst)
      shift_en |=> sr_ff[0] == $past(sdi_sync_ff))
      else $error("serial bit not captured on falling edge");

   edge_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      shift_en && !fs_fall && cnt_ff != EDGES_SAT |=> cnt_ff == CNT_W'($past(cnt_ff) + 1'b1))
      else $error("edge counter did not advance");

   idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
      fs_sync_ff |=> $stable(sr_ff) && $stable(cnt_ff) && $stable(sdo_ff))
      else $error("shifter moved while frame select high");

   short_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
      fs_rise && cnt_ff < EDGES_KEEP && !pend_ff |=> !pend_ff)
      else $error("short frame was kept");

   frame_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
      fs_rise && cnt_ff >= EDGES_FULL && !pend_ff |=> pend_ff && pend_frame_ff == $past(sr_ff))
      else $error("complete frame not latched on frame select rise");

   chain_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
      shift_en && !fs_fall |=> o_sdo == $past(sr_ff[FRAME_BITS-1]))
      else $error("chain output is not the delayed input");

   broadcast_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
      exec && cmd_code == CMD_BROADCAST |=> out_ff[NUM_CH-1] == $past(cmd_data) && hold_ff[CH_A] == $past(cmd_data))
      else $error("broadcast did not load all registers");

   update_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
      exec && cmd_code == CMD_UPDATE_SEL && cmd_ff[2] |=> out_ff[2] == $past(hold_ff[2]))
      else $error("selected channel not updated from holding register");

   buffered_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
      exec && cmd_code == 4'h3 && !write_through_mode_ff |=> $stable(out_ff[3]) && hold_ff[3] == $past(cmd_data))
      else $error("buffered write touched output register");

   mode_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
      exec && cmd_code == CMD_WRITE_THROUGH_MODE |=> o_write_through ##1 o_write_through || $past(exec))
      else $error("write-through mode not entered");
endmodule

// file: tb/dscif_host.sv
/*
 Serial host model: drives frame select, link clock and data, watches the chain output.
 Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps
module dscif_host
(
   input wire logic i_sdo,
   output logic o_frame_sel_n,
   output logic o_sclk,
   output logic o_sdi
);
   // Link clock idles high and, except while stray pulses it, stands still between frames
   initial
   begin
      o_frame_sel_n = 1'b1;
      o_sclk = 1'b1;
      o_sdi = 1'b0;
   end

   // Shifts n bits from bits[31] down; seen collects the chain output just before each rise, 100 ns after each fall
   task automatic send(input logic [31:0] bits, input int n, output logic [31:0] seen);
      seen = '0;
      o_frame_sel_n = 1'b0;
      #100;
      for (int i = 0; i < n; i++)
      begin
         o_sdi = bits[31-i];
         #100 o_sclk = 1'b0;
         #100 seen = {seen[30:0], i_sdo};
         o_sclk = 1'b1;
      end
      #100 o_frame_sel_n = 1'b1;
      o_sdi = 1'b0;
      #200;
   endtask

   // Clock pulses with frame select high must change nothing
   task automatic stray(input logic [31:0] bits);
      for (int i = 0; i < 16; i++)
      begin
         o_sdi = bits[i];
         #100 o_sclk = 1'b0;
         #100 o_sclk = 1'b1;
      end
      o_sdi = 1'b0;
   endtask
endmodule

// file: tb/dscif_bench.sv
/*
 Self-checking bench of the serial command front end with a host model.
 Assumes a 12-bit build as the main target, with a 10-bit build beside it on the same pins;
 expectations come from a behavioural model.
*/
`timescale 1ns/1ps
module dscif_bench
   import dscif_pkg::*;
;
   logic i_clk, i_rst, fs_n, sclk, sdi, o_sdo, o_write_through;
   logic [NUM_CH*CODE_W-1:0] o_dac_code;
   logic [NUM_CH*CODE_W-1:0] o_dac_code_b;
   logic [NUM_CH*2-1:0] o_sleep_state;
   logic [CODE_W-1:0] m_hold[NUM_CH];
   logic [CODE_W-1:0] m_out[NUM_CH];
   logic [1:0] m_sleep[NUM_CH];
   logic m_wt;
   int error_cnt = 0;
   int compares = 0;
   integer seed = 32'h80c35b73;
   logic [31:0] seen;
   logic [15:0] fr, fr2;

   dscif_core #(.DAC_BITS(12), .DEPTH(FIFO_DEPTH)) i_dscif_core (.i_clk(i_clk), .i_rst(i_rst),
      .i_frame_sel_n(fs_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(o_sdo), .o_dac_code(o_dac_code),
      .o_sleep_state(o_sleep_state), .o_write_through(o_write_through));
   // The 10-bit build only differs in its data mask, so only its codes are compared
   dscif_core #(.DAC_BITS(10), .DEPTH(FIFO_DEPTH)) i_dscif_core_b (.i_clk(i_clk), .i_rst(i_rst),
      .i_frame_sel_n(fs_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(), .o_dac_code(o_dac_code_b),
      .o_sleep_state(), .o_write_through());
   dscif_host i_dscif_host (.i_sdo(o_sdo), .o_frame_sel_n(fs_n), .o_sclk(sclk), .o_sdi(sdi));

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic void model_reset();
      for (int i = 0; i < NUM_CH; i++)
      begin
         m_hold[i] = CODE_RESET;
         m_out[i] = CODE_RESET;
         m_sleep[i] = SLEEP_AWAKE;
      end
      m_wt = 1'b0;
   endfunction

   // Channels wake whenever their output register is loaded or copied
   function automatic void model(input logic [15:0] f);
      logic [3:0] c;
      logic [11:0] d;
      c = f[15:12];
      d = f[11:0];
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (c == i[3:0])
         begin
            m_hold[i] = d;
            if (m_wt)
            begin
               m_out[i] = d;
               m_sleep[i] = SLEEP_AWAKE;
            end
         end
         if ((c == CMD_UPDATE_SEL && d[i]) || (c == CMD_UPDATE_A && i != CH_A))
         begin
            m_out[i] = m_hold[i];
            m_sleep[i] = SLEEP_AWAKE;
         end
         if (c == CMD_BROADCAST || (c == CMD_UPDATE_A && i == CH_A))
         begin
            m_hold[i] = d;
            m_out[i] = d;
            m_sleep[i] = SLEEP_AWAKE;
         end
         if (d[i] && c == CMD_SLEEP_2K5)
            m_sleep[i] = SLEEP_2K5;
         if (d[i] && c == CMD_SLEEP_100K)
            m_sleep[i] = SLEEP_100K;
         if (d[i] && c == CMD_SLEEP_HIZ)
            m_sleep[i] = SLEEP_HIZ;
      end
      if (c == CMD_WRITE_THROUGH_MODE)
         m_wt = 1'b1;
      if (c == CMD_BUFFERED_WRITE_MODE)
         m_wt = 1'b0;
   endfunction

   // Step off the clock edge so outputs are read where they are settled
   task automatic check_all();
      #7;
      for (int i = 0; i < NUM_CH; i++)
      begin
         check(o_dac_code[i*CODE_W +: CODE_W], m_out[i], "code");
         check(o_dac_code_b[i*CODE_W +: CODE_W], m_out[i] & MASK_10BIT, "code 10-bit");
         check(o_sleep_state[i*2 +: 2], m_sleep[i], "sleep");
      end
      check(o_write_through, m_wt, "mode");
   endtask

   // Ten cycles cover the six or seven the command needs to reach the outputs
   task automatic frame(input logic [15:0] f);
      @(posedge i_clk);
      #7;
      i_dscif_host.send({f, 16'h0000}, 16, seen);
      model(f);
      repeat (10) @(posedge i_clk);
   endtask

   initial
   begin
      repeat (100000) @(posedge i_clk);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      finish_test();
   end

   initial
   begin
      i_rst = 1'b1;
      model_reset();
      repeat (16) @(posedge i_clk);
      #7 i_rst = 1'b0;
      repeat (4) @(posedge i_clk);
      check_all();
      $display("Test reset done");
      // Codes 0..15, then channel writes again now that write-through is on
      for (int k = 0; k < 24; k++)
      begin
         fr = {k[3:0], 12'($random(seed))};
         frame(fr);
         check_all();
      end
      $display("Test codes done");
      for (int k = 0; k < 40; k++)
      begin
         frame(16'($random(seed)));
         check_all();
      end
      $display("Test random done");
      for (int n = 8; n < 16; n += 7)
      begin
         @(posedge i_clk);
         #7;
         i_dscif_host.send($random(seed), n, seen);
         repeat (10) @(posedge i_clk);
         check_all();
      end
      $display("Test short frames done");
      @(posedge i_clk);
      #7;
      i_dscif_host.stray($random(seed));
      repeat (10) @(posedge i_clk);
      check_all();
      frame({CMD_BROADCAST, 12'($random(seed))});
      check_all();
      $display("Test stray clock done");
      fr = 16'($random(seed));
      fr2 = {4'h3, 12'($random(seed))};
      @(posedge i_clk);
      #7;
      i_dscif_host.send({fr, fr2}, 32, seen);
      check(seen, {16'h0000, fr}, "chain output");
      model(fr2);
      repeat (10) @(posedge i_clk);
      check_all();
      $display("Test chain done");
      @(posedge i_clk);
      #7 i_rst = 1'b1;
      repeat (3) @(posedge i_clk);
      #7 i_rst = 1'b0;
      model_reset();
      repeat (4) @(posedge i_clk);
      check_all();
      $display("Test second reset done");
      finish_test();
   end
endmodule
